// file: rtl/drive_supervisory_logic.sv
// Purpose: run timer, analog window, fan, sleep/wake, overload, stall settings, auto fault reset
// Assumes: analog inputs are 12-bit codes, 4095 = full scale = 10.00 V; temperatures in degC
// Notes: current is percent of rated current times 1; all times counted in 0.1 s ticks
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "dsl_defines.svh"
// Contract
// - timer enable: 0 leaves the run timer off, 1 enables timed running.
// - when timer reaches duration, stop drive and assert primary relay output.
// - count restarts from zero each start; remaining time readable.
// - duration source: preset, or analog one to three scaled to preset.
// - preset in tenth minutes, 0 to 6500.0, default zero.
// - fast output flags first analog input outside low/high window.
// - fast output flags heatsink at or above threshold, 0..100, default 75.
// - fan mode 0: fan while running; stopped, fan by 40 degree threshold.
// - fan mode 1: fan always on from power-up.
// - running: sleep after reference at or below sleep frequency for delay.
// - sleeping with run command: wake after reference at or above wake frequency for delay.
// - both frequencies zero disables sleep; sleep limited to wake frequency.
// - setting chooses whether process loop computes during sleep.
// - overload protection enable, default 1; 0 disables judgement.
// - inverse-time trip: 220% x gain 1 min, 150% x gain 60 min.
// - pre-alarm on fast output at curve times pre-warning coefficient.
// - stall gain 0..100 default 30, stall voltage 650..800 default 770.
// - stall settings alias the acceleration-group settings.
// - auto reset up to count 0..20; beyond that stay in fault.
// - setting chooses whether fast output acts during auto reset.
// - wait interval 0.1..100.0 s between fault and each reset; the written tick count is taken unclamped.
module drive_supervisory_logic
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [3:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdData,
   input wire dsl_pkg::dsl_analog_s analogIn,
   input wire logic [7:0] heatsinkTemp,
   input wire logic [15:0] freqRef,
   input wire logic [15:0] motorCurrentPct,
   input wire logic runCommand,
   input wire logic driveFault,
   output logic runRequest,
   output logic faultResetPulse,
   output logic faultLatched,
   output logic loopComputeEnable,
   output logic primaryRelayOutput,
   output logic fastDigitalOutput,
   output logic fanOn,
   output logic overloadTrip
);
   // ------------------------------------------------------------
   // synchronisers for pin-side inputs
   // ------------------------------------------------------------
   logic [1:0] runCmdSync_r;
   logic [1:0] faultSync_r;
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         runCmdSync_r <= 2'h0;
         faultSync_r <= 2'h0;
      end
      else
      begin
         runCmdSync_r <= {runCmdSync_r[0], runCommand};
         faultSync_r <= {faultSync_r[0], driveFault};
      end
   end
   wire logic runCmd = runCmdSync_r[1];
   wire logic fault = faultSync_r[1];

   // ------------------------------------------------------------
   // settings registers
   // ------------------------------------------------------------
   dsl_pkg::dsl_ctrl_s ctrl_r;
   logic [15:0] runTimePreset_r;
   logic [15:0] analogWindowLow_r;
   logic [15:0] analogWindowHigh_r;
   logic [7:0] heatsinkTempThreshold_r;
   logic [15:0] wakeFrequency_r;
   logic [15:0] sleepFrequency_r;
   logic [15:0] wakeDelay_r;
   logic [15:0] sleepDelay_r;
   logic [15:0] overloadCurveGain_r;
   logic [7:0] overloadPrewarnCoeff_r;
   logic [7:0] stallGain_r;
   logic [15:0] stallVoltage_r;
   logic [7:0] autoResetCount_r;
   logic [15:0] autoResetInterval_r;

   function automatic logic [15:0] clampHi(input logic [15:0] v, input logic [15:0] hi);
      clampHi = (v > hi) ? hi : v;
   endfunction

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ctrl_r <= dsl_pkg::dsl_ctrl_s'(`DSL_RST_CTRL << 2);
         runTimePreset_r <= 16'h0;
         analogWindowLow_r <= 16'(`DSL_RST_WINDOW & 32'h0000_ffff);
         analogWindowHigh_r <= 16'(`DSL_RST_WINDOW >> 16);
         heatsinkTempThreshold_r <= `DSL_RST_TEMP;
         wakeFrequency_r <= 16'h0;
         sleepFrequency_r <= 16'h0;
         wakeDelay_r <= 16'h0;
         sleepDelay_r <= 16'h0;
         overloadCurveGain_r <= 16'(`DSL_RST_OVLD & 32'h0000_ffff);
         overloadPrewarnCoeff_r <= 8'(`DSL_RST_OVLD >> 16);
         stallGain_r <= 8'(`DSL_RST_STALL & 32'h0000_00ff);
         stallVoltage_r <= 16'(`DSL_RST_STALL >> 16);
         autoResetCount_r <= 8'h0;
         autoResetInterval_r <= 16'(`DSL_RST_RESET >> 16);
      end
      else if (regWr)
      begin
         if (regAddr == `DSL_A_CTRL)
            ctrl_r <= dsl_pkg::dsl_ctrl_s'({23'h0, regWrData[8:2], 2'h0});
         else if (regAddr == `DSL_A_RUNTIME)
            runTimePreset_r <= clampHi(regWrData[15:0], `DSL_MAX_RUNTIME);
         else if (regAddr == `DSL_A_WINDOW)
         begin
            analogWindowLow_r <= regWrData[15:0];
            analogWindowHigh_r <= (regWrData[31:16] < regWrData[15:0]) ? regWrData[15:0] : regWrData[31:16];
         end
         else if (regAddr == `DSL_A_TEMP)
            heatsinkTempThreshold_r <= (regWrData[7:0] > `DSL_MAX_TEMP) ? `DSL_MAX_TEMP : regWrData[7:0];
         else if (regAddr == `DSL_A_WAKE)
         begin
            wakeFrequency_r <= regWrData[15:0];
            wakeDelay_r <= clampHi(regWrData[31:16], `DSL_MAX_RUNTIME);
            sleepFrequency_r <= clampHi(sleepFrequency_r, regWrData[15:0]);
         end
         else if (regAddr == `DSL_A_SLEEP)
         begin
            sleepFrequency_r <= clampHi(regWrData[15:0], wakeFrequency_r);
            sleepDelay_r <= clampHi(regWrData[31:16], `DSL_MAX_RUNTIME);
         end
         else if (regAddr == `DSL_A_OVLD)
         begin
            overloadCurveGain_r <= regWrData[15:0];
            overloadPrewarnCoeff_r <= regWrData[23:16];
         end
         else if (regAddr == `DSL_A_STALL)
         begin
            // one register serves both setting groups, so they can never disagree
            stallGain_r <= (regWrData[7:0] > `DSL_MAX_STALLG) ? `DSL_MAX_STALLG : regWrData[7:0];
            stallVoltage_r <= (regWrData[31:16] < `DSL_MIN_STALLV) ? `DSL_MIN_STALLV :
                              clampHi(regWrData[31:16], `DSL_MAX_STALLV);
         end
         else if (regAddr == `DSL_A_RESET)
         begin
            autoResetCount_r <= (regWrData[7:0] > `DSL_MAX_RETRY) ? `DSL_MAX_RETRY : regWrData[7:0];
            autoResetInterval_r <= regWrData[31:16];
         end
      end
   end

   // ------------------------------------------------------------
   // common tick
   // ------------------------------------------------------------
   logic [20:0] tickCnt_r;
   logic tick_r;
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         tickCnt_r <= 21'h0;
         tick_r <= 1'b0;
      end
      else if (tickCnt_r == 21'(`DSL_TICK_CYC - 1))
      begin
         tickCnt_r <= 21'h0;
         tick_r <= 1'b1;
      end
      else
      begin
         tickCnt_r <= tickCnt_r + 21'h1;
         tick_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // run timer and sleep/wake
   // ------------------------------------------------------------
   logic [11:0] srcAnalog;
   logic [31:0] scaled;
   logic [15:0] runLimit;
   always_comb
   begin
      srcAnalog = 12'h0;
      if (ctrl_r.runTimeSourceSelect == 2'h1)
         srcAnalog = analogIn.analogInputFirst;
      else if (ctrl_r.runTimeSourceSelect == 2'h2)
         srcAnalog = analogIn.analogInputSecond;
      else if (ctrl_r.runTimeSourceSelect == 2'h3)
         srcAnalog = analogIn.analogInputThird;
      scaled = (32'(srcAnalog) * 32'(runTimePreset_r)) / 32'hfff;
      runLimit = (ctrl_r.runTimeSourceSelect == 2'h0) ? runTimePreset_r : scaled[15:0];
   end

   dsl_pkg::dsl_run_e runState_r;
   dsl_pkg::dsl_flt_e fltState_r;
   logic [15:0] runTenths_r;
   logic [15:0] minTick_r;
   logic [15:0] swDelay_r;
   wire logic sleepOn = (wakeFrequency_r != 16'h0) || (sleepFrequency_r != 16'h0);
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         runState_r <= dsl_pkg::DSL_IDLE;
         runTenths_r <= 16'h0;
         minTick_r <= 16'h0;
         swDelay_r <= 16'h0;
      end
      else
      begin
         case (runState_r)
            dsl_pkg::DSL_IDLE:
            begin
               runTenths_r <= 16'h0;
               minTick_r <= 16'h0;
               swDelay_r <= 16'h0;
               if (runCmd && !fault && fltState_r == dsl_pkg::DSL_OK)
                  runState_r <= dsl_pkg::DSL_RUN;
            end
            dsl_pkg::DSL_RUN:
            begin
               if (!runCmd || fault)
                  runState_r <= dsl_pkg::DSL_IDLE;
               else if (ctrl_r.runTimerEnable && runTenths_r >= runLimit)
                  runState_r <= dsl_pkg::DSL_DONE;
               else if (tick_r)
               begin
                  if (ctrl_r.runTimerEnable)
                  begin
                     if (minTick_r == `DSL_MIN_TICKS / 16'd10 - 16'd1)
                     begin
                        minTick_r <= 16'h0;
                        runTenths_r <= runTenths_r + 16'h1;
                     end
                     else
                        minTick_r <= minTick_r + 16'h1;
                  end
                  if (sleepOn && freqRef <= sleepFrequency_r)
                  begin
                     if (swDelay_r >= sleepDelay_r)
                     begin
                        swDelay_r <= 16'h0;
                        runState_r <= dsl_pkg::DSL_SLEEP;
                     end
                     else
                        swDelay_r <= swDelay_r + 16'h1;
                  end
                  else
                     swDelay_r <= 16'h0;
               end
            end
            dsl_pkg::DSL_SLEEP:
            begin
               if (!runCmd || fault)
                  runState_r <= dsl_pkg::DSL_IDLE;
               else if (tick_r)
               begin
                  if (freqRef >= wakeFrequency_r)
                  begin
                     if (swDelay_r >= wakeDelay_r)
                     begin
                        swDelay_r <= 16'h0;
                        runState_r <= dsl_pkg::DSL_RUN;
                     end
                     else
                        swDelay_r <= swDelay_r + 16'h1;
                  end
                  else
                     swDelay_r <= 16'h0;
               end
            end
            dsl_pkg::DSL_DONE:
               if (!runCmd)
                  runState_r <= dsl_pkg::DSL_IDLE;
            default:
               runState_r <= dsl_pkg::DSL_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // overload integrator
   // ------------------------------------------------------------
   // heat rises by the excess of current over 150% x gain; trip level fixed so
   // that 220% x gain lasts 1 min; 150% x gain itself is caught by a 60 min counter
   logic [31:0] olBase;
   logic [31:0] olHigh;
   logic [31:0] olExcess;
   logic [31:0] olLimit;
   always_comb
   begin
      olBase = (32'(`DSL_OL_LO_PCT) * 32'(overloadCurveGain_r)) / 32'd100;
      olHigh = (32'(`DSL_OL_HI_PCT) * 32'(overloadCurveGain_r)) / 32'd100;
      olExcess = (32'(motorCurrentPct) > olBase) ? 32'(motorCurrentPct) - olBase : 32'h0;
      olLimit = (olHigh - olBase) * `DSL_OL_HI_TICKS;
   end
   logic [31:0] olHeat_r;
   logic [31:0] olLoTicks_r;
   always_ff @(posedge clk)
   begin
      if (srst || !ctrl_r.overloadProtectEnable)
      begin
         olHeat_r <= 32'h0;
         olLoTicks_r <= 32'h0;
      end
      else if (tick_r)
      begin
         if (olExcess != 32'h0)
            olHeat_r <= (olHeat_r + olExcess > olLimit) ? olLimit : olHeat_r + olExcess;
         else
            olHeat_r <= (olHeat_r > 32'h0) ? olHeat_r - 32'h1 : 32'h0;
         if (32'(motorCurrentPct) >= olBase)
            olLoTicks_r <= (olLoTicks_r < `DSL_OL_LO_TICKS) ? olLoTicks_r + 32'h1 : olLoTicks_r;
         else
            olLoTicks_r <= 32'h0;
      end
   end
   wire logic olTrip = ctrl_r.overloadProtectEnable &&
                       ((olHeat_r >= olLimit && olLimit != 32'h0) || olLoTicks_r >= `DSL_OL_LO_TICKS);
   wire logic olWarn = ctrl_r.overloadProtectEnable && (olHeat_r * 32'd100 >=
                       olLimit * 32'(overloadPrewarnCoeff_r)) && olHeat_r != 32'h0;

   // ------------------------------------------------------------
   // automatic fault reset
   // ------------------------------------------------------------
   logic [7:0] retries_r;
   logic [15:0] fltWait_r;
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         fltState_r <= dsl_pkg::DSL_OK;
         retries_r <= 8'h0;
         fltWait_r <= 16'h0;
         faultResetPulse <= 1'b0;
      end
      else
      begin
         faultResetPulse <= 1'b0;
         case (fltState_r)
            dsl_pkg::DSL_OK:
               if (fault)
                  fltState_r <= dsl_pkg::DSL_FAULT;
            dsl_pkg::DSL_FAULT:
            begin
               fltWait_r <= 16'h0;
               if (retries_r >= autoResetCount_r)
                  fltState_r <= dsl_pkg::DSL_LATCH;
               else
                  fltState_r <= dsl_pkg::DSL_WAIT;
            end
            dsl_pkg::DSL_WAIT:
               if (tick_r)
               begin
                  if (fltWait_r + 16'h1 >= autoResetInterval_r)
                  begin
                     faultResetPulse <= 1'b1;
                     retries_r <= retries_r + 8'h1;
                     fltState_r <= dsl_pkg::DSL_OK;
                  end
                  else
                     fltWait_r <= fltWait_r + 16'h1;
               end
            dsl_pkg::DSL_LATCH:
               if (!runCmd && !fault)
               begin
                  retries_r <= 8'h0;
                  fltState_r <= dsl_pkg::DSL_OK;
               end
            default:
               fltState_r <= dsl_pkg::DSL_OK;
         endcase
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   wire logic inReset = (fltState_r == dsl_pkg::DSL_WAIT) || (fltState_r == dsl_pkg::DSL_FAULT);
   wire logic windowOut = (32'(analogIn.analogInputFirst) * 32'd1000 / 32'hfff < 32'(analogWindowLow_r)) ||
                          (32'(analogIn.analogInputFirst) * 32'd1000 / 32'hfff > 32'(analogWindowHigh_r));
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         runRequest <= 1'b0;
         faultLatched <= 1'b0;
         loopComputeEnable <= 1'b0;
         primaryRelayOutput <= 1'b0;
         fastDigitalOutput <= 1'b0;
         fanOn <= 1'b0;
         overloadTrip <= 1'b0;
      end
      else
      begin
         runRequest <= (runState_r == dsl_pkg::DSL_RUN);
         faultLatched <= (fltState_r == dsl_pkg::DSL_LATCH);
         loopComputeEnable <= (runState_r == dsl_pkg::DSL_RUN) ||
                              (runState_r == dsl_pkg::DSL_SLEEP && ctrl_r.loopKeepSleep);
         primaryRelayOutput <= (runState_r == dsl_pkg::DSL_DONE);
         fastDigitalOutput <= (windowOut || heatsinkTemp >= heatsinkTempThreshold_r || olWarn) &&
                              (!inReset || ctrl_r.outOnReset);
         if (ctrl_r.fanMode)
            fanOn <= 1'b1;
         else if (runState_r == dsl_pkg::DSL_RUN)
            fanOn <= 1'b1;
         else if (heatsinkTemp > `DSL_FAN_ON_DEGC)
            fanOn <= 1'b1;
         else if (heatsinkTemp < `DSL_FAN_ON_DEGC)
            fanOn <= 1'b0;
         overloadTrip <= olTrip;
      end
   end

   // ------------------------------------------------------------
   // register readback
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (srst)
         regRdData <= 32'h0;
      else if (!regRd)
         regRdData <= 32'h0;
      else if (regAddr == `DSL_A_CTRL)
         regRdData <= 32'(ctrl_r);
      else if (regAddr == `DSL_A_RUNTIME)
         regRdData <= {16'h0, runTimePreset_r};
      else if (regAddr == `DSL_A_WINDOW)
         regRdData <= {analogWindowHigh_r, analogWindowLow_r};
      else if (regAddr == `DSL_A_TEMP)
         regRdData <= {24'h0, heatsinkTempThreshold_r};
      else if (regAddr == `DSL_A_WAKE)
         regRdData <= {wakeDelay_r, wakeFrequency_r};
      else if (regAddr == `DSL_A_SLEEP)
         regRdData <= {sleepDelay_r, sleepFrequency_r};
      else if (regAddr == `DSL_A_OVLD)
         regRdData <= {8'h0, overloadPrewarnCoeff_r, overloadCurveGain_r};
      else if (regAddr == `DSL_A_STALL)
         regRdData <= {stallVoltage_r, 8'h0, stallGain_r};
      else if (regAddr == `DSL_A_RESET)
         regRdData <= {autoResetInterval_r, 8'h0, autoResetCount_r};
      else if (regAddr == `DSL_A_STATUS)
         regRdData <= {20'h0, retries_r, fltState_r, runState_r};
      else if (regAddr == `DSL_A_REMAIN)
         regRdData <= {16'h0, (runLimit > runTenths_r) ? runLimit - runTenths_r : 16'h0};
      else
         regRdData <= 32'h0;
   end
endmodule
`default_nettype wire

// file: rtl/dsl_defines.svh
// Purpose: constants for drive supervisory logic
// Assumes: 20 MHz clock, tenth-unit settings
// Notes: offsets are word indices on the plain register port
`ifndef DSL_DEFINES_SVH
`define DSL_DEFINES_SVH
`define DSL_CLK_HZ 20000000
`define DSL_TICK_MS 100
`define DSL_TICK_CYC ((`DSL_CLK_HZ / 1000) * `DSL_TICK_MS)
`define DSL_MIN_TICKS 16'd600
`define DSL_FAN_ON_DEGC 8'd40
`define DSL_OL_HI_PCT 16'd220
`define DSL_OL_LO_PCT 16'd150
`define DSL_OL_HI_TICKS 32'd600
`define DSL_OL_LO_TICKS 32'd36000
`define DSL_A_CTRL 4'h0
`define DSL_A_RUNTIME 4'h1
`define DSL_A_WINDOW 4'h2
`define DSL_A_TEMP 4'h3
`define DSL_A_WAKE 4'h4
`define DSL_A_SLEEP 4'h5
`define DSL_A_OVLD 4'h6
`define DSL_A_STALL 4'h7
`define DSL_A_RESET 4'h8
`define DSL_A_STATUS 4'h9
`define DSL_A_REMAIN 4'ha
`define DSL_RST_CTRL 32'h0000_0001
`define DSL_RST_WINDOW 32'h02a8_0136
`define DSL_RST_TEMP 8'd75
`define DSL_RST_OVLD 32'h0050_0064
`define DSL_RST_STALL 32'h0302_001e
`define DSL_RST_RESET 32'h000a_0000
`define DSL_MAX_RETRY 8'd20
`define DSL_MAX_RUNTIME 16'd65000
`define DSL_MAX_TEMP 8'd100
`define DSL_MAX_STALLG 8'd100
`define DSL_MIN_STALLV 16'd650
`define DSL_MAX_STALLV 16'd800
`endif

// file: rtl/dsl_pkg.sv
// Purpose: types for drive supervisory logic
// Assumes: none
// Notes: field layout of the control register
package dsl_pkg;
   typedef enum logic [1:0] {DSL_IDLE, DSL_RUN, DSL_SLEEP, DSL_DONE} dsl_run_e;
   typedef enum logic [1:0] {DSL_OK, DSL_FAULT, DSL_WAIT, DSL_LATCH} dsl_flt_e;
   typedef struct packed {
      logic [22:0] spare;
      logic outOnReset;
      logic loopKeepSleep;
      logic fanMode;
      logic [1:0] runTimeSourceSelect;
      logic runTimerEnable;
      logic overloadProtectEnable;
      logic [1:0] unused;
   } dsl_ctrl_s;
   typedef struct packed {
      logic [11:0] analogInputFirst;
      logic [11:0] analogInputSecond;
      logic [11:0] analogInputThird;
   } dsl_analog_s;
endpackage

// file: dv/dsl_core_model.sv
// Purpose: drive core stand-in that issues run and fault levels
// Assumes: bench commands arrive just after clk edges
// Notes: a fault is only reported while the core is running
`timescale 1ns/10ps
`default_nettype none
module dsl_core_model
(
   input wire logic clk,
   input wire logic startCmd,
   input wire logic faultInject,
   input wire logic runRequest,
   output var logic runCommand = 1'b0,
   output var logic driveFault = 1'b0
);
   always @(posedge clk)
   begin
      runCommand <= startCmd;
      driveFault <= faultInject & runRequest;
   end
endmodule
`default_nettype wire

// file: dv/dsl_checker_properties.sv
// Purpose: port assertions for drive supervisory logic
// Assumes: one clock, srst synchronous active high
// Notes: mirrors fan mode and temp threshold from register writes
`timescale 1ns/10ps
`default_nettype none
`include "dsl_defines.svh"
module dsl_checker
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [3:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWr,
   input wire logic [7:0] heatsinkTemp,
   input wire logic runCommand,
   input wire logic driveFault,
   input wire logic runRequest,
   input wire logic faultResetPulse,
   input wire logic faultLatched,
   input wire logic primaryRelayOutput,
   input wire logic fastDigitalOutput,
   input wire logic fanOn
);
   logic fanModeR;
   logic faultEverR;
   logic [7:0] tempThrR;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         fanModeR <= 1'b0;
         tempThrR <= `DSL_RST_TEMP;
      end
      else if (regWr && regAddr == `DSL_A_CTRL)
         fanModeR <= regWrData[6];
      else if (regWr && regAddr == `DSL_A_TEMP)
         tempThrR <= (regWrData[7:0] > `DSL_MAX_TEMP) ? `DSL_MAX_TEMP : regWrData[7:0];
   end
   always_ff @(posedge clk)
   begin
      faultEverR <= srst ? 1'b0 : (faultEverR | driveFault);
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   sequence hotHold;
      (heatsinkTemp > `DSL_FAN_ON_DEGC)[*4];
   endsequence
   sequence coldIdle;
      (heatsinkTemp < `DSL_FAN_ON_DEGC && !runCommand && !runRequest && !fanModeR)[*6];
   endsequence
   sequence overTemp;
      (heatsinkTemp >= tempThrR && !faultEverR && !faultLatched)[*4];
   endsequence
   AST_FAN_HOT: assert property (hotHold |-> fanOn)
      else $error("fan off while heatsink hot");
   AST_FAN_COLD: assert property (coldIdle |-> !fanOn)
      else $error("fan on while stopped and cool");
   AST_FAN_ALWAYS: assert property (fanModeR [*4] |-> fanOn)
      else $error("fan off in continuous mode");
   AST_HOT_FLAG: assert property (overTemp |-> fastDigitalOutput)
      else $error("overheat flag missing");
   AST_RUN_START: assert property ($rose(runCommand) && !runRequest && !faultEverR && !primaryRelayOutput
      |-> ##[2:5] runRequest)
      else $error("run request late after run command");
   AST_LATCH_STOP: assert property (faultLatched |-> !runRequest)
      else $error("running while fault latched");
   AST_RELAY_STOP: assert property ($rose(primaryRelayOutput) |-> ##[0:2] !runRequest)
      else $error("drive not stopped at timer expiry");
   AST_PULSE: assert property (faultResetPulse |=> !faultResetPulse)
      else $error("reset attempts without interval");
endmodule
bind drive_supervisory_logic dsl_checker u_chk (.clk, .srst, .regAddr, .regWrData, .regWr, .heatsinkTemp,
   .runCommand, .driveFault, .runRequest, .faultResetPulse, .faultLatched, .primaryRelayOutput,
   .fastDigitalOutput, .fanOn);
`default_nettype wire

// file: dv/drive_supervisory_logic_test.sv
// Purpose: self-checking bench for drive supervisory logic
// Assumes: 20 MHz clock, 0.1 s tick too long to reach
// Notes: covers registers, fan, output flags and start
`timescale 1ns/10ps
`default_nettype none
`include "dsl_defines.svh"
module drive_supervisory_logic_test;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [3:0] regAddr = 4'h0;
   logic [31:0] regWrData = 32'h0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [31:0] regRdData;
   dsl_pkg::dsl_analog_s analogIn = '{12'h800, 12'h000, 12'h000};
   logic [7:0] heatsinkTemp = 8'h14;
   logic [15:0] freqRef = 16'h1388;
   logic startCmd = 1'b0;
   logic faultInject = 1'b0;
   logic runCommand, driveFault, runRequest, faultResetPulse, faultLatched, loopComputeEnable;
   logic primaryRelayOutput, fastDigitalOutput, fanOn, overloadTrip;
   int badCount = 0;
   int samplesChecked = 0;
   always #25ns clk = ~clk;
   dsl_core_model u_core (.clk, .startCmd, .faultInject, .runRequest, .runCommand, .driveFault);
   drive_supervisory_logic u_dut (.clk, .srst, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
      .analogIn, .heatsinkTemp, .freqRef, .motorCurrentPct(16'h0064), .runCommand, .driveFault,
      .runRequest, .faultResetPulse, .faultLatched, .loopComputeEnable, .primaryRelayOutput,
      .fastDigitalOutput, .fanOn, .overloadTrip);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp)
      begin
         badCount++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rdCheck(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      @(negedge clk);
      check(regRdData, exp);
   endtask
   task automatic waitCheck(ref logic sig, input logic exp);
      for (int i = 0; i < 16 && sig !== exp; i++)
         @(negedge clk);
      check({31'h0, sig}, {31'h0, exp});
      @(posedge clk);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic testDefaults;
      rdCheck(`DSL_A_CTRL, 32'h0000_0004);
      rdCheck(`DSL_A_WINDOW, 32'h02a8_0136);
      rdCheck(`DSL_A_TEMP, 32'h0000_004b);
      rdCheck(`DSL_A_OVLD, 32'h0050_0064);
      rdCheck(`DSL_A_STALL, 32'h0302_001e);
      rdCheck(`DSL_A_RESET, 32'h000a_0000);
      rdCheck(`DSL_A_RUNTIME, 32'h0);
      rdCheck(4'hf, 32'h0);
   endtask
   task automatic testClamp;
      wr(`DSL_A_TEMP, 32'h0000_00c8);
      rdCheck(`DSL_A_TEMP, 32'h0000_0064);
      wr(`DSL_A_STALL, 32'h0000_00ff);
      rdCheck(`DSL_A_STALL, 32'h028a_0064);
      wr(`DSL_A_RESET, 32'h000a_001e);
      rdCheck(`DSL_A_RESET, 32'h000a_0014);
      wr(`DSL_A_RUNTIME, 32'h0000_ffff);
      rdCheck(`DSL_A_RUNTIME, 32'h0000_fde8);
      wr(`DSL_A_WAKE, 32'h0000_0064);
      wr(`DSL_A_SLEEP, 32'h0000_01f4);
      rdCheck(`DSL_A_SLEEP, 32'h0000_0064);
      wr(`DSL_A_TEMP, 32'h0000_004b);
   endtask
   task automatic testFan;
      heatsinkTemp <= 8'h32;
      waitCheck(fanOn, 1'b1);
      heatsinkTemp <= 8'h1e;
      waitCheck(fanOn, 1'b0);
      wr(`DSL_A_CTRL, 32'h0000_0044);
      waitCheck(fanOn, 1'b1);
      wr(`DSL_A_CTRL, 32'h0000_0004);
      waitCheck(fanOn, 1'b0);
   endtask
   task automatic testFlags;
      heatsinkTemp <= 8'h50;
      waitCheck(fastDigitalOutput, 1'b1);
      heatsinkTemp <= 8'h14;
      waitCheck(fastDigitalOutput, 1'b0);
      analogIn.analogInputFirst <= 12'hfff;
      waitCheck(fastDigitalOutput, 1'b1);
      analogIn.analogInputFirst <= 12'h800;
      waitCheck(fastDigitalOutput, 1'b0);
      analogIn.analogInputFirst <= 12'h000;
      waitCheck(fastDigitalOutput, 1'b1);
   endtask
   task automatic testRun;
      wr(`DSL_A_CTRL, 32'h0000_000c);
      wr(`DSL_A_RUNTIME, 32'h0000_0001);
      startCmd <= 1'b1;
      waitCheck(runRequest, 1'b1);
      rdCheck(`DSL_A_REMAIN, 32'h0000_0001);
      check({31'h0, primaryRelayOutput}, 32'h0);
      check({31'h0, overloadTrip}, 32'h0);
      wr(`DSL_A_RUNTIME, 32'h0);
      waitCheck(primaryRelayOutput, 1'b1);
      rdCheck(`DSL_A_STATUS, 32'h0000_0003);
      startCmd <= 1'b0;
      waitCheck(primaryRelayOutput, 1'b0);
   endtask
   task automatic testFault;
      wr(`DSL_A_CTRL, 32'h0000_0004);
      wr(`DSL_A_RESET, 32'h000a_0000);
      startCmd <= 1'b1;
      waitCheck(runRequest, 1'b1);
      faultInject <= 1'b1;
      waitCheck(faultLatched, 1'b1);
      rdCheck(`DSL_A_STATUS, 32'h0000_000c);
      startCmd <= 1'b0;
      waitCheck(faultLatched, 1'b0);
   endtask
   task automatic finishTest;
      $display("checks %0d errors %0d", samplesChecked, badCount);
      if (badCount == 0 && samplesChecked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      repeat (4'ha) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      testDefaults();
      testClamp();
      testFan();
      testFlags();
      testRun();
      testFault();
      finishTest();
   end
   initial
   begin
      #2ms;
      badCount++;
      finishTest();
   end
endmodule
`default_nettype wire
